// ### pkg/iac_map.svh
`ifndef IAC_MAP_SVH
`define IAC_MAP_SVH

// register byte offsets on the axi4-lite port
`define IAC_OFS_CTRL        8'h00
`define IAC_OFS_STATUS      8'h04
`define IAC_OFS_OWN_ADDR    8'h08
`define IAC_OFS_IRQ_STATUS  8'h0c
`define IAC_OFS_IRQ_CLEAR   8'h10
`define IAC_OFS_IRQ_ENABLE  8'h14
`define IAC_OFS_LINES       8'h18

// control register fields
`define IAC_CTRL_RATE2      7
`define IAC_CTRL_ENABLE     6
`define IAC_CTRL_ACK        2
`define IAC_CTRL_RATE1      1
`define IAC_CTRL_RATE0      0
`define IAC_CTRL_MASK       8'hc7

// serial status register fields
`define IAC_ST_GC           7
`define IAC_ST_STOP         6
`define IAC_ST_INTERRUPT_FLAG         5
`define IAC_ST_TX           4
`define IAC_ST_BUSY         3
`define IAC_ST_LOST         2
`define IAC_ST_NACK         1
`define IAC_ST_SLV          0

// interrupt event bits
`define IAC_EV_OWN_ADDR     0
`define IAC_EV_GCALL        1
`define IAC_EV_BYTE         2
`define IAC_EV_STOP         3

// reset values
`define IAC_RST_CTRL        8'h00
`define IAC_RST_OWN_ADDR    8'h00
`define IAC_RST_IRQ_ENABLE  4'h0

// master scl divisors, one per rate code
`define IAC_DIV_000         10'h010
`define IAC_DIV_001         10'h018
`define IAC_DIV_010         10'h01e
`define IAC_DIV_011         10'h03c
`define IAC_DIV_100         10'h078
`define IAC_DIV_101         10'h0f0
`define IAC_DIV_110         10'h1e0
`define IAC_DIV_111         10'h3c0

// axi response codes
`define IAC_RESP_OKAY       2'h0
`define IAC_RESP_SLVERR     2'h2

`endif

// ### pkg/iac_pkg.sv
package iac_pkg;

	// byte-level events and bus state from the shift/match engine
	typedef struct packed {
		logic own_addr_rx;
		logic gcall_rx;
		logic byte_done;
		logic arb_lost;
		logic stop_seen;
		logic master;
		logic transmitter;
		logic slave_sel;
		logic bus_busy;
		logic nack_seen;
		logic ack_slot;
		logic ack_addr;
		logic ack_data;
	} iac_event_type;

	// control fields handed to the engine
	typedef struct packed {
		logic [2:0] rate;
		logic       enable;
		logic       ack_enable;
	} iac_ctrl_type;

	// scl generator states, gray along idle-low-high
	typedef enum logic [1:0] {
		IAC_SCL_IDLE = 2'b00,
		IAC_SCL_LOW  = 2'b01,
		IAC_SCL_HIGH = 2'b11
	} iac_scl_state_type;

endpackage : iac_pkg

// ### rtl/iac_scl_gen.sv
`timescale 1ns/1ps
`include "iac_map.svh"

module iac_scl_gen (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       run,
	input  wire logic [2:0] rate,
	output logic            scl_drive_low
);
	import iac_pkg::*;

	iac_scl_state_type state;
	logic [9:0]        count;
	logic [9:0]        half;
	logic [9:0]        div_full;

	// divisor per rate code, top bit most significant
	function automatic logic [9:0] divisor(input logic [2:0] code);
		case (code)
			3'b000:  divisor = `IAC_DIV_000;
			3'b001:  divisor = `IAC_DIV_001;
			3'b010:  divisor = `IAC_DIV_010;
			3'b011:  divisor = `IAC_DIV_011;
			3'b100:  divisor = `IAC_DIV_100;
			3'b101:  divisor = `IAC_DIV_101;
			3'b110:  divisor = `IAC_DIV_110;
			default: divisor = `IAC_DIV_111;
		endcase
	endfunction : divisor

	// every divisor is even, so the halves are exact
	assign div_full = divisor(rate);
	assign half     = {1'b0, div_full[9:1]};

	// low half then high half of each scl period
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= IAC_SCL_IDLE;
			count <= 10'h000;
		end else begin
			case (state)
				IAC_SCL_IDLE: begin
					count <= 10'h000;
					if (run) state <= IAC_SCL_LOW;
				end
				IAC_SCL_LOW: begin
					if (count >= half - 10'h001) begin
						count <= 10'h000;
						state <= IAC_SCL_HIGH;
					end else count <= count + 10'h001;
				end
				IAC_SCL_HIGH: begin
					if (count >= half - 10'h001) begin
						count <= 10'h000;
						state <= run ? IAC_SCL_LOW : IAC_SCL_IDLE;
					end else count <= count + 10'h001;
				end
				default: state <= IAC_SCL_IDLE;
			endcase
		end
	end

	assign scl_drive_low = (state == IAC_SCL_LOW);

endmodule : iac_scl_gen

// ### rtl/iac_ctrl.sv
`timescale 1ns/1ps
`include "iac_map.svh"

module iac_ctrl (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [7:0]            awaddr,
	input  wire logic                  awvalid,
	output logic                       awready,
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output logic                       wready,
	output logic [1:0]                 bresp,
	output logic                       bvalid,
	input  wire logic                  bready,
	input  wire logic [7:0]            araddr,
	input  wire logic                  arvalid,
	output logic                       arready,
	output logic [31:0]                rdata,
	output logic [1:0]                 rresp,
	output logic                       rvalid,
	input  wire logic                  rready,
	input  wire logic                  sda_in,
	output logic                       sda_out,
	output logic                       sda_oe_n,
	input  wire logic                  scl_in,
	output logic                       scl_out,
	output logic                       scl_oe_n,
	input  wire iac_pkg::iac_event_type bus_event,
	output iac_pkg::iac_ctrl_type      ctrl,
	output logic [6:0]                 own_address,
	output logic                       general_call_enable,
	output logic                       sda_line,
	output logic                       scl_line,
	output logic                       interrupt_flag,
	output logic                       irq
);
	import iac_pkg::*;

	logic [7:0]  ctrl_reg;
	logic [7:0]  own_address_reg;
	logic [7:0]  serial_status_reg;
	logic [3:0]  irq_status;
	logic [3:0]  irq_enable;
	logic        gc_flag;
	logic        stop_flag;
	logic        lost_flag;
	logic [1:0]  sda_sync;
	logic [1:0]  scl_sync;
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        do_write;
	logic        rd_take;
	logic        status_read;
	logic        ack_enable;
	logic        enable;
	logic [3:0]  next_event;
	logic        set_interrupt_flag;
	logic        ack_drive;
	logic        scl_drive_low;
	logic [31:0] next_rdata;
	logic        next_rerr;

	// true when the byte address hits a mapped register
	function automatic logic mapped(input logic [7:0] a);
		case (a)
			`IAC_OFS_CTRL, `IAC_OFS_STATUS, `IAC_OFS_OWN_ADDR,
			`IAC_OFS_IRQ_STATUS, `IAC_OFS_IRQ_CLEAR,
			`IAC_OFS_IRQ_ENABLE, `IAC_OFS_LINES: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction : mapped

	assign enable     = ctrl_reg[`IAC_CTRL_ENABLE];
	assign ack_enable = ctrl_reg[`IAC_CTRL_ACK];

	// two-flop synchronisers on the bus lines; only the second stage, index 1, is read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sda_sync <= 2'h3;
			scl_sync <= 2'h3;
		end else begin
			sda_sync <= {sda_sync[0], sda_in};
			scl_sync <= {scl_sync[0], scl_in};
		end
	end
	assign sda_line = sda_sync[1];
	assign scl_line = scl_sync[1];

	// write channel: address and data are taken in either order
	assign awready  = !aw_held && !bvalid;
	assign wready   = !w_held && !bvalid;
	assign do_write = aw_held && w_held && !bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held   <= 1'b0;
			w_held    <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_held   <= 1'b1;
				aw_addr_q <= awaddr;
			end else if (do_write) aw_held <= 1'b0;
			if (wvalid && wready) begin
				w_held   <= 1'b1;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end else if (do_write) w_held <= 1'b0;
		end
	end

	// write response, slverr for unmapped addresses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= `IAC_RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp  <= mapped(aw_addr_q) ? `IAC_RESP_OKAY : `IAC_RESP_SLVERR;
		end else if (bready) bvalid <= 1'b0;
	end

	// software registers; status and lines ignore writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg        <= `IAC_RST_CTRL;
			own_address_reg <= `IAC_RST_OWN_ADDR;
			irq_enable      <= `IAC_RST_IRQ_ENABLE;
		end else if (do_write && w_strb_q[0]) begin
			case (aw_addr_q)
				`IAC_OFS_CTRL:       ctrl_reg <= w_data_q[7:0] & `IAC_CTRL_MASK;
				`IAC_OFS_OWN_ADDR:   own_address_reg <= w_data_q[7:0];
				`IAC_OFS_IRQ_ENABLE: irq_enable <= w_data_q[3:0];
				default:             ctrl_reg <= ctrl_reg;
			endcase
		end
	end

	assign ctrl.rate            = {ctrl_reg[`IAC_CTRL_RATE2],
	                               ctrl_reg[`IAC_CTRL_RATE1],
	                               ctrl_reg[`IAC_CTRL_RATE0]};
	assign ctrl.enable          = enable;
	assign ctrl.ack_enable      = ack_enable;
	assign own_address          = own_address_reg[7:1];
	assign general_call_enable  = own_address_reg[0];

	// events that raise the interrupt flag
	always_comb begin
		next_event = 4'h0;
		next_event[`IAC_EV_OWN_ADDR] = bus_event.own_addr_rx && ack_enable;
		next_event[`IAC_EV_GCALL]    = bus_event.gcall_rx && general_call_enable
		                               && ack_enable;
		next_event[`IAC_EV_BYTE]     = bus_event.byte_done
		                               && (bus_event.master
		                               || bus_event.slave_sel);
		next_event[`IAC_EV_STOP]     = bus_event.stop_seen && bus_event.slave_sel;
	end
	assign set_interrupt_flag = enable && (next_event != 4'h0);

	// read channel; status read is the side-effect strobe
	assign arready     = !rvalid;
	assign rd_take     = arvalid && arready;
	assign status_read = rd_take && (araddr == `IAC_OFS_STATUS);

	// interrupt flag: a new event wins over the clear on read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			interrupt_flag <= 1'b0;
		end else if (set_interrupt_flag) begin
			interrupt_flag <= 1'b1;
		end else if (status_read) begin
			interrupt_flag <= 1'b0;
		end
	end

	// sticky gc, stop and lost flags, cleared with the status read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gc_flag   <= 1'b0;
			stop_flag <= 1'b0;
			lost_flag <= 1'b0;
		end else begin
			if (enable && next_event[`IAC_EV_GCALL]) gc_flag <= 1'b1;
			else if (status_read) gc_flag <= 1'b0;
			if (enable && next_event[`IAC_EV_STOP]) stop_flag <= 1'b1;
			else if (status_read) stop_flag <= 1'b0;
			if (enable && bus_event.arb_lost) lost_flag <= 1'b1;
			else if (status_read) lost_flag <= 1'b0;
		end
	end

	// status vector: gc, stop, flag and lost from flops; tx, busy, nack and slv taken live from the engine
	always_comb begin
		serial_status_reg = 8'h00;
		serial_status_reg[`IAC_ST_GC]   = gc_flag;
		serial_status_reg[`IAC_ST_STOP] = stop_flag;
		serial_status_reg[`IAC_ST_INTERRUPT_FLAG] = interrupt_flag;
		serial_status_reg[`IAC_ST_TX]   = bus_event.transmitter;
		serial_status_reg[`IAC_ST_BUSY] = bus_event.bus_busy;
		serial_status_reg[`IAC_ST_LOST] = lost_flag;
		serial_status_reg[`IAC_ST_NACK] = bus_event.nack_seen;
		serial_status_reg[`IAC_ST_SLV]  = bus_event.slave_sel;
	end

	// sticky interrupt sources; set wins over a write-one clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status <= 4'h0;
		end else begin
			if (do_write && w_strb_q[0] && aw_addr_q == `IAC_OFS_IRQ_CLEAR) begin
				irq_status <= (irq_status & ~w_data_q[3:0])
				              | (enable ? next_event : 4'h0);
			end else begin
				irq_status <= irq_status | (enable ? next_event : 4'h0);
			end
		end
	end

	// level interrupt while any enabled source is pending
	always_ff @(posedge aclk) begin
		if (!aresetn) irq <= 1'b0;
		else          irq <= |(irq_status & irq_enable);
	end

	// read data mux
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_rerr  = 1'b0;
		case (araddr)
			`IAC_OFS_CTRL:       next_rdata[7:0] = ctrl_reg;
			`IAC_OFS_STATUS:     next_rdata[7:0] = serial_status_reg;
			`IAC_OFS_OWN_ADDR:   next_rdata[7:0] = own_address_reg;
			`IAC_OFS_IRQ_STATUS: next_rdata[3:0] = irq_status;
			`IAC_OFS_IRQ_CLEAR:  next_rdata      = 32'h0000_0000; // write-only
			`IAC_OFS_IRQ_ENABLE: next_rdata[3:0] = irq_enable;
			`IAC_OFS_LINES:      next_rdata[1:0] = {scl_line, sda_line};
			default:             next_rerr       = 1'b1;
		endcase
	end

	// read answer registered one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= `IAC_RESP_OKAY;
		end else if (rd_take) begin
			rvalid <= 1'b1;
			rdata  <= next_rdata;
			rresp  <= next_rerr ? `IAC_RESP_SLVERR : `IAC_RESP_OKAY;
		end else if (rready) rvalid <= 1'b0;
	end

	// acknowledge decision, only inside the ack clock pulse
	always_comb begin
		ack_drive = 1'b0;
		if (enable && ack_enable && bus_event.ack_slot) begin
			if (bus_event.ack_addr) ack_drive = 1'b1;
			else if (bus_event.ack_data && !bus_event.transmitter) begin
				if (bus_event.master)         ack_drive = 1'b1;
				else if (bus_event.slave_sel) ack_drive = 1'b1;
			end
		end
	end

	// sda pulled low only to acknowledge; ack off leaves it released
	always_ff @(posedge aclk) begin
		if (!aresetn) sda_oe_n <= 1'b1;
		else          sda_oe_n <= !ack_drive;
	end
	assign sda_out = 1'b0;

	// master clock generator; stops outside master mode or when disabled
	iac_scl_gen u_scl_gen (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.run           (enable && bus_event.master),
		.rate          (ctrl.rate),
		.scl_drive_low (scl_drive_low)
	);

	// scl is open drain: only ever pulled low, released when disabled
	always_ff @(posedge aclk) begin
		if (!aresetn) scl_oe_n <= 1'b1;
		else          scl_oe_n <= !(enable && scl_drive_low);
	end
	assign scl_out = 1'b0;

endmodule : iac_ctrl

// ### sim/iac_ctrl_properties.sv
`timescale 1ns/1ps
`include "iac_map.svh"

module iac_ctrl_properties (
	input wire logic                   aclk,
	input wire logic                   aresetn,
	input wire logic [7:0]             araddr,
	input wire logic                   arvalid,
	input wire logic                   arready,
	input wire logic                   sda_oe_n,
	input wire logic                   scl_oe_n,
	input wire iac_pkg::iac_event_type bus_event,
	input wire iac_pkg::iac_ctrl_type  ctrl,
	input wire logic                   general_call_enable,
	input wire logic                   interrupt_flag
);
	import iac_pkg::*;
	localparam logic [9:0] HALF [8] = '{10'h008, 10'h00c, 10'h00f, 10'h01e,
		10'h03c, 10'h078, 10'h0f0, 10'h1e0};
	logic       p_scl;
	logic       clean;
	logic       run;
	logic [9:0] seg;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	assign run = ctrl.enable && bus_event.master;
	// phase length; a phase counts only if the generator ran through all of it
	always_ff @(posedge aclk) begin
		p_scl <= scl_oe_n;
		if (!aresetn || scl_oe_n != p_scl) begin
			seg   <= 10'h001;
			clean <= aresetn && run;
		end else begin
			seg   <= seg + 10'h001;
			clean <= clean && run;
		end
	end
	sequence s_ack;
		ctrl.enable && ctrl.ack_enable && bus_event.ack_slot;
	endsequence
	sequence s_rx_data;
		bus_event.ack_data && !bus_event.transmitter;
	endsequence
	sequence s_stat_rd;
		arvalid && arready && araddr == `IAC_OFS_STATUS;
	endsequence
	sequence s_no_ev;
		!(bus_event.own_addr_rx || bus_event.gcall_rx || bus_event.byte_done
			|| bus_event.stop_seen);
	endsequence
	AST_ACK_ADDR: assert property (s_ack ##0 bus_event.ack_addr |=> !sda_oe_n)
		else $error("no ack after own address");
	AST_ACK_MRX: assert property (s_ack ##0 s_rx_data ##0 bus_event.master |=> !sda_oe_n)
		else $error("master receiver did not ack");
	AST_ACK_SRX: assert property (s_ack ##0 s_rx_data ##0 bus_event.slave_sel |=> !sda_oe_n)
		else $error("slave receiver did not ack");
	AST_NO_ACK: assert property (!ctrl.ack_enable |=> sda_oe_n)
		else $error("sda pulled with ack disabled");
	AST_SCL_HALF: assert property (scl_oe_n != p_scl && clean && run |-> seg == HALF[ctrl.rate])
		else $error("scl phase length wrong");
	AST_OWN_IRQ: assert property (bus_event.own_addr_rx && ctrl.enable && ctrl.ack_enable
		|=> interrupt_flag)
		else $error("own address did not set flag");
	AST_GC_IRQ: assert property (bus_event.gcall_rx && general_call_enable && ctrl.enable
		&& ctrl.ack_enable |=> interrupt_flag)
		else $error("general call did not set flag");
	AST_MBYTE_IRQ: assert property (bus_event.byte_done && bus_event.master && ctrl.enable
		|=> interrupt_flag)
		else $error("master byte did not set flag");
	AST_SBYTE_IRQ: assert property (bus_event.byte_done && bus_event.slave_sel && ctrl.enable
		|=> interrupt_flag)
		else $error("slave byte did not set flag");
	AST_STOP_IRQ: assert property (bus_event.stop_seen && bus_event.slave_sel && ctrl.enable
		|=> interrupt_flag)
		else $error("stop did not set flag");
	AST_RD_CLR: assert property (s_stat_rd ##0 s_no_ev |=> !interrupt_flag)
		else $error("status read left flag set");
	AST_OFF_FLOAT: assert property (!ctrl.enable [*3] |-> sda_oe_n && scl_oe_n)
		else $error("lines driven while disabled");
endmodule : iac_ctrl_properties

bind iac_ctrl iac_ctrl_properties u_props (.aclk, .aresetn, .araddr, .arvalid, .arready,
	.sda_oe_n, .scl_oe_n, .bus_event, .ctrl, .general_call_enable, .interrupt_flag);

// ### sim/iac_bus_model.sv
`timescale 1ns/1ps

module iac_bus_model (
	input  wire logic sda_out,
	input  wire logic sda_oe_n,
	input  wire logic scl_out,
	input  wire logic scl_oe_n,
	input  wire logic peer_sda_low,
	output logic      sda_in,
	output logic      scl_in
);
	// pulled-up open-drain wires: any party pulling low wins, released reads high
	assign sda_in = (sda_oe_n || sda_out) && !peer_sda_low;
	assign scl_in = scl_oe_n || scl_out;
endmodule : iac_bus_model

// ### sim/iac_ctrl_tb.sv
`timescale 1ns/1ps
`include "iac_map.svh"

module iac_ctrl_tb;
	import iac_pkg::*;
	logic          aclk = 1'b0;
	logic          aresetn = 1'b0;
	logic [7:0]    awaddr = 8'h00;
	logic [7:0]    araddr = 8'h00;
	logic [31:0]   wdata = 32'h0000_0000;
	logic [3:0]    wstrb = 4'hf;
	logic          awvalid = 1'b0;
	logic          wvalid = 1'b0;
	logic          bready = 1'b0;
	logic          arvalid = 1'b0;
	logic          rready = 1'b0;
	logic          peer_sda_low = 1'b0;
	iac_event_type bus_event = '0;
	iac_event_type base = '0;
	logic          awready, wready, bvalid, arready, rvalid, irq, interrupt_flag;
	logic          sda_in, sda_out, sda_oe_n, scl_in, scl_out, scl_oe_n;
	logic          general_call_enable, sda_line, scl_line;
	logic [1:0]    bresp, rresp, rr;
	logic [31:0]   rdata, rv;
	logic [6:0]    own_address;
	iac_ctrl_type  ctrl;
	int            n_errors = 0;
	int            checked = 0;
	int            cyc = 0;

	iac_ctrl u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .sda_in, .sda_out, .sda_oe_n, .scl_in, .scl_out, .scl_oe_n,
		.bus_event, .ctrl, .own_address, .general_call_enable, .sda_line, .scl_line,
		.interrupt_flag, .irq);
	iac_bus_model u_bus (.sda_out, .sda_oe_n, .scl_out, .scl_oe_n, .peer_sda_low,
		.sda_in, .scl_in);

	initial begin
		forever #20 aclk = ~aclk;
	end
	// a hang counts as a mismatch
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			tally_and_finish;
		end
	end

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// ready is looked at in the low half, where it equals its value at the next edge
	task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, tb;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			r  = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end while (!tb);
		bready <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tv;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(negedge aclk);
			ta = arvalid && arready;
			tv = rvalid;
			d  = rdata;
			r  = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
		end while (!tv);
		rready <= 1'b0;
	endtask : rd

	// one-cycle event pulse on top of the held levels in base
	task pulse(input iac_event_type p);
		@(posedge aclk);
		bus_event <= iac_event_type'(p | base);
		@(posedge aclk);
		bus_event <= base;
		@(negedge aclk);
	endtask : pulse

	task t_regs;
		rd(`IAC_OFS_CTRL, rv, rr);
		chk("ctrl_rst", `IAC_RST_CTRL, rv);
		rd(`IAC_OFS_OWN_ADDR, rv, rr);
		chk("own_rst", `IAC_RST_OWN_ADDR, rv);
		rd(`IAC_OFS_IRQ_ENABLE, rv, rr);
		chk("ien_rst", `IAC_RST_IRQ_ENABLE, rv);
		rd(`IAC_OFS_LINES, rv, rr);
		chk("lines_idle", 32'h0000_0003, rv);
		chk("pins_low", 2'b00, {sda_out, scl_out});
		wr(`IAC_OFS_CTRL, 32'hffff_ffff, rr);
		chk("wr_okay", `IAC_RESP_OKAY, rr);
		rd(`IAC_OFS_CTRL, rv, rr);
		chk("ctrl_mask", `IAC_CTRL_MASK, rv);
		chk("ctrl_out", 5'h1f, ctrl);
		base.transmitter = 1'b1;
		base.bus_busy    = 1'b1;
		base.nack_seen   = 1'b1;
		pulse('0);
		wr(`IAC_OFS_STATUS, 32'h0000_00ff, rr);
		rd(`IAC_OFS_STATUS, rv, rr);
		chk("status_ro", 32'h0000_001a, rv);
		base = '0;
		wr(`IAC_OFS_CTRL, 32'h0000_0000, rr);
		wr(8'h1c, 32'h0000_0000, rr);
		chk("bad_wr", `IAC_RESP_SLVERR, rr);
		rd(8'h1c, rv, rr);
		chk("bad_rd", `IAC_RESP_SLVERR, rr);
		chk("bad_rdata", 32'h0000_0000, rv);
		peer_sda_low <= 1'b1;
		// the line passes two synchroniser flops before the register sees it
		repeat (2) @(posedge aclk);
		rd(`IAC_OFS_LINES, rv, rr);
		chk("lines_sda", 32'h0000_0002, rv);
		chk("sda_line", 1'b0, sda_line);
		peer_sda_low <= 1'b0;
	endtask : t_regs

	// rows: enable, ack, master, slave, transmitter, addr slot, data slot, ack expected
	task t_ack;
		logic [7:0]    tbl [6];
		iac_event_type p;
		tbl = '{8'hc5, 8'he3, 8'hd3, 8'hda, 8'h84, 8'h44};
		foreach (tbl[i]) begin
			wr(`IAC_OFS_CTRL, {tbl[i][7], 3'h0, tbl[i][6], 2'h0}, rr);
			base             = '0;
			base.master      = tbl[i][5];
			base.slave_sel   = tbl[i][4];
			base.transmitter = tbl[i][3];
			p                = '0;
			p.ack_slot       = 1'b1;
			p.ack_addr       = tbl[i][2];
			p.ack_data       = tbl[i][1];
			pulse(p);
			chk("sda_oe_n", !tbl[i][0], sda_oe_n);
		end
		base = '0;
	endtask : t_ack

	// rows: ack, master, slave, own, gcall, byte, stop, lost, then expected event bits
	task t_events;
		logic [11:0]   tbl [7];
		logic [3:0]    x;
		iac_event_type p;
		tbl = '{12'h901, 12'h100, 12'h882, 12'hc54, 12'ha44, 12'h840, 12'ha28};
		wr(`IAC_OFS_OWN_ADDR, 32'h0000_0055, rr);
		chk("own_address", 7'h2a, own_address);
		chk("gc_enable", 1'b1, general_call_enable);
		wr(`IAC_OFS_IRQ_ENABLE, 32'h0000_000d, rr);
		foreach (tbl[i]) begin
			x = tbl[i][3:0];
			wr(`IAC_OFS_CTRL, {1'b1, 3'h0, tbl[i][11], 2'h0}, rr);
			base           = '0;
			base.master    = tbl[i][10];
			base.slave_sel = tbl[i][9];
			p              = '0;
			p.own_addr_rx  = tbl[i][8];
			p.gcall_rx     = tbl[i][7];
			p.byte_done    = tbl[i][6];
			p.stop_seen    = tbl[i][5];
			p.arb_lost     = tbl[i][4];
			pulse(p);
			chk("interrupt_flag", |x, interrupt_flag);
			@(negedge aclk);
			chk("irq", |(x & 4'hd), irq);
			rd(`IAC_OFS_IRQ_STATUS, rv, rr);
			chk("irq_status", x, rv);
			rd(`IAC_OFS_STATUS, rv, rr);
			chk("status_top", {x[1], x[3], |x, 5'h00}, rv & 32'h0000_00e0);
			rd(`IAC_OFS_STATUS, rv, rr);
			chk("status_clr", 32'h0000_0000, rv & 32'h0000_00e0);
			wr(`IAC_OFS_IRQ_CLEAR, 32'h0000_000f, rr);
			rd(`IAC_OFS_IRQ_STATUS, rv, rr);
			chk("irq_clr", 32'h0000_0000, rv);
			chk("irq_low", 1'b0, irq);
		end
	endtask : t_events

	// inside the loop the rate is changed only while the generator is stopped
	task t_scl;
		int         n;
		logic [9:0] dv [8];
		dv = '{10'h010, 10'h018, 10'h01e, 10'h03c, 10'h078, 10'h0f0, 10'h1e0, 10'h3c0};
		for (int r = 0; r < 8; r++) begin
			base = '0;
			pulse('0);
			// the old period runs out first; each divisor beats the one before
			repeat (dv[r]) @(negedge aclk);
			wr(`IAC_OFS_CTRL, {r[2], 1'b1, 4'h0, r[1:0]}, rr);
			base.master = 1'b1;
			pulse('0);
			n = 0;
			while (scl_oe_n !== 1'b0 && n < 64) begin
				@(negedge aclk);
				n++;
			end
			n = 0;
			while (scl_oe_n === 1'b0 && n < 2000) begin
				@(negedge aclk);
				n++;
			end
			chk("scl_low", dv[r] >> 1, n);
			n = 0;
			while (scl_oe_n === 1'b1 && n < 2000) begin
				@(negedge aclk);
				n++;
			end
			chk("scl_high", dv[r] >> 1, n);
		end
		wr(`IAC_OFS_CTRL, 32'h0000_0000, rr);
		repeat (4) @(negedge aclk);
		chk("scl_off", 1'b1, scl_oe_n);
		chk("scl_line", 1'b1, scl_line);
		base = '0;
	endtask : t_scl

	task tally_and_finish;
		if (n_errors == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_ack;
		t_events;
		t_scl;
		tally_and_finish;
	end
endmodule : iac_ctrl_tb
